// ===== blrr_map.svh
// Constants of the boot loader execute and reset command path
`ifndef BLRR_MAP_SVH
`define BLRR_MAP_SVH

`define BLRR_CMD_EXEC     8'h22
`define BLRR_CMD_RESET    8'h25
`define BLRR_LEN_EXEC     8'h07
`define BLRR_LEN_RESET    8'h03
`define BLRR_LEN_MIN      8'h03
`define BLRR_ACK          8'hCC
`define BLRR_NAK          8'h33
`define BLRR_PAD          8'h00
`define BLRR_ADDR_BYTES   3'h4

`endif

// ===== blrr_pkg.sv
// Types shared by the boot loader command ends
package blrr_pkg;
  typedef logic [7:0]  blrr_byte_t;
  typedef logic [31:0] blrr_addr_t;
endpackage

// ===== blrr_link_if.sv
// Byte link between host end and loader end
`timescale 1ns/1ns
`default_nettype none
interface blrr_link_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  modport host (output h2d_data, output h2d_valid, input d2h_data, input d2h_valid);
  modport dev  (input h2d_data, input h2d_valid, output d2h_data, output d2h_valid);
endinterface
`default_nettype wire

// ===== blrr_dev.sv
// Loader end: decodes execute and reset packets, answers, then acts
`timescale 1ns/1ns
`default_nettype none
`include "blrr_map.svh"

module blrr_dev
  import blrr_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   rst,
  blrr_link_if.dev    link,
  output logic        run_req,
  output blrr_addr_t  run_addr,
  output logic        sw_reset_req
);

  // ----------------------------------------
  // Types and helpers
  // ----------------------------------------
  typedef enum logic [4:0] {
    BLRR_S_IDLE = 5'h01,
    BLRR_S_SUM  = 5'h02,
    BLRR_S_DATA = 5'h04,
    BLRR_S_ANS  = 5'h08,
    BLRR_S_ACT  = 5'h10
  } blrr_dstate_t;

  // Length within the sizes this path can carry
  function automatic logic len_ok(input blrr_byte_t len);
    len_ok = (len >= `BLRR_LEN_MIN) && (len <= `BLRR_LEN_EXEC);
  endfunction

  // Index of the last data byte for a length
  function automatic blrr_byte_t last_idx(input blrr_byte_t len);
    last_idx = len - `BLRR_LEN_MIN;
  endfunction

  // Modulo-256 sum
  function automatic blrr_byte_t sum8(input blrr_byte_t a, input blrr_byte_t b);
    sum8 = a + b;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  blrr_dstate_t state_ff;
  blrr_dstate_t nxt_state;
  blrr_byte_t   len_ff;
  blrr_byte_t   sum_ff;
  blrr_byte_t   acc_ff;
  blrr_byte_t   cmd_ff;
  blrr_byte_t   cnt_ff;
  blrr_addr_t   addr_ff;
  blrr_addr_t   run_addr_ff;
  logic         len_good_ff;
  logic         d2h_valid_ff;
  blrr_byte_t   d2h_data_ff;
  logic         run_ff;
  logic         rst_req_ff;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic       in_idle   = (state_ff == BLRR_S_IDLE);
  wire logic       in_sum    = (state_ff == BLRR_S_SUM);
  wire logic       in_data   = (state_ff == BLRR_S_DATA);
  wire logic       ans_now   = (state_ff == BLRR_S_ANS);
  wire logic       act_now   = (state_ff == BLRR_S_ACT);
  wire logic       byte_in   = link.h2d_valid;
  wire logic       first_nz  = byte_in && (link.h2d_data != `BLRR_PAD);
  wire logic       take_len  = in_idle && first_nz;
  wire logic       take_sum  = in_sum && byte_in;
  wire logic       take_data = in_data && byte_in;
  wire logic       take_cmd  = take_data && (cnt_ff == 8'h00);
  wire logic       take_addr = take_data && (cnt_ff != 8'h00);
  wire logic       last_data = take_data && (cnt_ff == last_idx(len_ff));
  wire logic       is_exec   = (cmd_ff == `BLRR_CMD_EXEC) &&
                               (len_ff == `BLRR_LEN_EXEC);
  wire logic       is_rst    = (cmd_ff == `BLRR_CMD_RESET) &&
                               (len_ff == `BLRR_LEN_RESET);
  wire logic       sum_match = (acc_ff == sum_ff);
  wire logic       pkt_good  = len_good_ff && sum_match && (is_exec || is_rst);
  wire logic       do_run    = act_now && is_exec;
  wire logic       do_rst    = act_now && is_rst;
  wire blrr_byte_t nxt_len   = len_ok(link.h2d_data) ? link.h2d_data : `BLRR_LEN_MIN;
  wire blrr_byte_t ans_byte  = pkt_good ? `BLRR_ACK : `BLRR_NAK;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BLRR_S_IDLE: begin
        if (first_nz) begin
          nxt_state = BLRR_S_SUM;
        end
      end
      BLRR_S_SUM: begin
        if (byte_in) begin
          nxt_state = BLRR_S_DATA;
        end
      end
      BLRR_S_DATA: begin
        if (last_data) begin
          nxt_state = BLRR_S_ANS;
        end
      end
      BLRR_S_ANS: begin
        nxt_state = pkt_good ? BLRR_S_ACT : BLRR_S_IDLE;
      end
      BLRR_S_ACT: begin
        nxt_state = BLRR_S_IDLE;
      end
      default: begin
        nxt_state = BLRR_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= BLRR_S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Packet capture
  // ----------------------------------------
  // Length byte and its range flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      len_ff      <= 8'h00;
      len_good_ff <= 1'b0;
    end else if (take_len) begin
      len_ff      <= nxt_len;
      len_good_ff <= len_ok(link.h2d_data);
    end
  end

  // Checksum byte
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sum_ff <= 8'h00;
    end else if (take_sum) begin
      sum_ff <= link.h2d_data;
    end
  end

  // Running sum and data byte count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_ff <= 8'h00;
      cnt_ff <= 8'h00;
    end else if (take_len) begin
      acc_ff <= 8'h00;
      cnt_ff <= 8'h00;
    end else if (take_data) begin
      acc_ff <= sum8(acc_ff, link.h2d_data);
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // Command byte
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_ff <= 8'h00;
    end else if (take_len) begin
      cmd_ff <= 8'h00;
    end else if (take_cmd) begin
      cmd_ff <= link.h2d_data;
    end
  end

  // Address shifts in most significant byte first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_ff <= 32'h0000_0000;
    end else if (take_addr) begin
      addr_ff <= {addr_ff[23:0], link.h2d_data};
    end
  end

  // ----------------------------------------
  // Answer and action
  // ----------------------------------------
  // Answer stands one cycle, then the link idles at padding
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      d2h_valid_ff <= 1'b0;
      d2h_data_ff  <= 8'h00;
    end else begin
      d2h_valid_ff <= ans_now;
      d2h_data_ff  <= ans_now ? ans_byte : `BLRR_PAD;
    end
  end

  // Action pulses follow the answer by one cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_ff     <= 1'b0;
      rst_req_ff <= 1'b0;
    end else begin
      run_ff     <= do_run;
      rst_req_ff <= do_rst;
    end
  end

  // Jump address presented with the jump request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_addr_ff <= 32'h0000_0000;
    end else if (do_run) begin
      run_addr_ff <= addr_ff;
    end
  end

  assign link.d2h_valid = d2h_valid_ff;
  assign link.d2h_data  = d2h_data_ff;
  assign run_req        = run_ff;
  assign run_addr       = run_addr_ff;
  assign sw_reset_req   = rst_req_ff;

endmodule // blrr_dev
`default_nettype wire

// ===== blrr_host.sv
// Host end: sends execute or reset packets and reports the answer
`timescale 1ns/1ns
`default_nettype none
`include "blrr_map.svh"
module blrr_host
  import blrr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  blrr_link_if.host        link,
  input  wire logic        exec_start,
  input  wire logic        reset_start,
  input  wire blrr_addr_t  exec_addr,
  output logic             busy,
  output logic             done,
  output logic             acked
);

  typedef enum logic [2:0] {
    BLRR_H_IDLE = 3'h1,
    BLRR_H_SEND = 3'h2,
    BLRR_H_WAIT = 3'h4
  } blrr_hstate_t;

  blrr_hstate_t state_ff;
  blrr_byte_t   pkt_ff [0:6];
  blrr_byte_t   idx_ff, len_ff;
  logic         valid_ff, busy_ff, done_ff, acked_ff;
  blrr_byte_t   data_ff;

  // ----------------------------------------
  // Packet build
  // ----------------------------------------
  wire blrr_byte_t exec_sum = `BLRR_CMD_EXEC + exec_addr[31:24] + exec_addr[23:16]
                              + exec_addr[15:8] + exec_addr[7:0];
  wire logic start  = exec_start || reset_start;
  wire logic answer = link.d2h_valid && (link.d2h_data != `BLRR_PAD);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= BLRR_H_IDLE;
      for (int i = 0; i < 7; i++) pkt_ff[i] <= 8'h00;
      idx_ff   <= 8'h00;
      len_ff   <= 8'h00;
      valid_ff <= 1'b0;
      data_ff  <= 8'h00;
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
      acked_ff <= 1'b0;
    end else begin
      done_ff  <= 1'b0;
      valid_ff <= 1'b0;
      case (state_ff)
        BLRR_H_IDLE: if (start) begin
          busy_ff <= 1'b1;
          idx_ff  <= 8'h00;
          state_ff <= BLRR_H_SEND;
          if (exec_start) begin
            len_ff    <= `BLRR_LEN_EXEC;
            pkt_ff[0] <= `BLRR_LEN_EXEC;
            pkt_ff[1] <= exec_sum;
            pkt_ff[2] <= `BLRR_CMD_EXEC;
            pkt_ff[3] <= exec_addr[31:24];
            pkt_ff[4] <= exec_addr[23:16];
            pkt_ff[5] <= exec_addr[15:8];
            pkt_ff[6] <= exec_addr[7:0];
          end else begin
            len_ff    <= `BLRR_LEN_RESET;
            pkt_ff[0] <= `BLRR_LEN_RESET;
            pkt_ff[1] <= `BLRR_CMD_RESET;
            pkt_ff[2] <= `BLRR_CMD_RESET;
          end
        end
        BLRR_H_SEND: begin
          valid_ff <= 1'b1;
          data_ff  <= pkt_ff[idx_ff[2:0]];
          idx_ff   <= idx_ff + 8'h01;
          if (idx_ff == len_ff - 8'h01) state_ff <= BLRR_H_WAIT;
        end
        BLRR_H_WAIT: if (answer) begin
          acked_ff <= (link.d2h_data == `BLRR_ACK);
          done_ff  <= 1'b1;
          busy_ff  <= 1'b0;
          state_ff <= BLRR_H_IDLE;
        end
        default: state_ff <= BLRR_H_IDLE;
      endcase
    end
  end

  assign link.h2d_valid = valid_ff;
  assign link.h2d_data  = data_ff;
  assign busy           = busy_ff;
  assign done           = done_ff;
  assign acked          = acked_ff;

endmodule // blrr_host
`default_nettype wire

// ===== blrr_link_chk.sv
// Assertions on the link joining host end and loader end
`timescale 1ns/1ns
`default_nettype none
`include "blrr_map.svh"
module blrr_link_chk
  import blrr_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       run_req,
  input wire logic       sw_reset_req
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  wire ack = d2h_valid && (d2h_data == `BLRR_ACK);
  wire nak = d2h_valid && (d2h_data == `BLRR_NAK);
  chk_ack_first_run: assert property (run_req |-> $past(ack))
    else $error("jump without prior acknowledge");
  chk_ack_first_rst: assert property (sw_reset_req |-> $past(ack))
    else $error("reset without prior acknowledge");
  chk_answer_code: assert property (d2h_valid |-> (ack || nak))
    else $error("answer byte not ACK or NAK");
  chk_nak_no_act: assert property (nak |=> !(run_req || sw_reset_req))
    else $error("action after negative acknowledge");
  chk_ack_acts: assert property (ack |=> (run_req ^ sw_reset_req))
    else $error("acknowledge not followed by one action");
  chk_answer_time: assert property (d2h_valid |-> $past(h2d_valid, 2) && !$past(h2d_valid))
    else $error("answer not two cycles after last byte");
  chk_run_pulse: assert property (run_req |=> !run_req)
    else $error("jump request longer than one cycle");
  chk_one_action: assert property (!(run_req && sw_reset_req))
    else $error("jump and reset together");
  cover property (ack ##1 run_req);
  cover property (ack ##1 sw_reset_req);
  cover property (h2d_valid && h2d_data == `BLRR_LEN_EXEC);
endmodule // blrr_link_chk
`default_nettype wire

// ===== test_boot_loader_run_reset_cmds.sv
// Self-checking bench for the execute and reset command ends
`timescale 1ns/1ns
`default_nettype none
`include "blrr_map.svh"
module test_boot_loader_run_reset_cmds
  import blrr_pkg::*;
;
  logic        core_clk, rst, exec_start, reset_start, busy, done, acked;
  logic        run_req, sw_reset_req, run_req_b, sw_reset_req_b;
  blrr_addr_t  exec_addr, run_addr, run_addr_b;
  blrr_byte_t  seen[$];
  int          num_errors, n_tests, runs, resets, acts_b;
  logic [31:0] seed;
  blrr_link_if link_a ();
  blrr_link_if link_b ();
  blrr_host blrr_host_inst (.core_clk(core_clk), .rst(rst), .link(link_a),
    .exec_start(exec_start), .reset_start(reset_start), .exec_addr(exec_addr),
    .busy(busy), .done(done), .acked(acked));
  blrr_dev blrr_dev_inst (.core_clk(core_clk), .rst(rst), .link(link_a),
    .run_req(run_req), .run_addr(run_addr), .sw_reset_req(sw_reset_req));
  blrr_dev blrr_dev_inst2 (.core_clk(core_clk), .rst(rst), .link(link_b),
    .run_req(run_req_b), .run_addr(run_addr_b), .sw_reset_req(sw_reset_req_b));
  blrr_link_chk blrr_link_chk_inst (.core_clk(core_clk), .rst(rst),
    .h2d_data(link_a.h2d_data), .h2d_valid(link_a.h2d_valid),
    .d2h_data(link_a.d2h_data), .d2h_valid(link_a.d2h_valid),
    .run_req(run_req), .sw_reset_req(sw_reset_req));
  function automatic logic [31:0] xorshift(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic blrr_byte_t exec_sum(blrr_addr_t a);
    return `BLRR_CMD_EXEC + a[31:24] + a[23:16] + a[15:8] + a[7:0];
  endfunction
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (link_a.h2d_valid === 1'b1) seen.push_back(link_a.h2d_data);
    if (run_req === 1'b1) runs++;
    if (sw_reset_req === 1'b1) resets++;
    if ((run_req_b | sw_reset_req_b) === 1'b1) acts_b++;
  end
  task automatic host_op(logic is_exec, blrr_addr_t a);
    int i;
    int r0;
    int s0;
    r0 = runs;
    s0 = resets;
    seen.delete();
    exec_addr = a;
    exec_start = is_exec;
    reset_start = !is_exec;
    @(negedge core_clk);
    exec_start = 1'b0;
    reset_start = 1'b0;
    check("busy", 1, busy);
    for (i = 0; i < 60 && done !== 1'b1; i++) @(negedge core_clk);
    check("done", 1, done);
    check("acked", 1, acked);
    check("busy idle", 0, busy);
    repeat (2) @(negedge core_clk);
    check("length", is_exec ? `BLRR_LEN_EXEC : `BLRR_LEN_RESET, seen[0]);
    if (is_exec) begin
      check("sum", exec_sum(a), seen[1]);
      check("cmd", `BLRR_CMD_EXEC, seen[2]);
      check("addr bytes", a, {seen[3], seen[4], seen[5], seen[6]});
      check("run addr", a, run_addr);
      check("runs", r0 + 1, runs);
      check("resets", s0, resets);
    end else begin
      check("sum", `BLRR_CMD_RESET, seen[1]);
      check("cmd", `BLRR_CMD_RESET, seen[2]);
      check("resets", s0 + 1, resets);
      check("runs", r0, runs);
    end
    $display("host test ends, %0d mismatches", num_errors);
  endtask
  task automatic send_b(blrr_byte_t pkt[$], blrr_byte_t ans);
    int i;
    int a0;
    a0 = acts_b;
    foreach (pkt[k]) begin
      link_b.h2d_data = pkt[k];
      link_b.h2d_valid = 1'b1;
      @(negedge core_clk);
    end
    link_b.h2d_valid = 1'b0;
    link_b.h2d_data = ~link_b.h2d_data;
    for (i = 0; i < 20 && link_b.d2h_valid !== 1'b1; i++) @(negedge core_clk);
    check("answer", ans, link_b.d2h_data);
    repeat (2) @(negedge core_clk);
    check("actions", a0 + (ans == `BLRR_ACK), acts_b);
    $display("loader test ends, %0d mismatches", num_errors);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #50000;
    num_errors++;
    results();
  end
  initial begin
    rst = 1'b1;
    exec_start = 1'b0;
    reset_start = 1'b0;
    exec_addr = 32'h00000000;
    link_b.h2d_data = 8'h00;
    link_b.h2d_valid = 1'b0;
    seed = 32'h0000_CCE2;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    host_op(1'b1, 32'h00000000);
    host_op(1'b1, 32'hFFFFFFFF);
    host_op(1'b0, 32'h12345678);
    for (int k = 0; k < 8; k++) begin
      seed = xorshift(seed);
      host_op(seed[3], seed);
    end
    send_b('{8'h00, 8'h00, 8'h03, 8'h25, 8'h25}, `BLRR_ACK);
    send_b('{8'h03, 8'h24, 8'h25}, `BLRR_NAK);
    send_b('{8'h03, 8'h20, 8'h20}, `BLRR_NAK);
    send_b('{8'h09, 8'h25, 8'h25}, `BLRR_NAK);
    send_b('{8'h03, 8'h22, 8'h22}, `BLRR_NAK);
    send_b('{8'h05, 8'h25, 8'h25, 8'h00, 8'h00}, `BLRR_NAK);
    send_b('{8'h07, 8'h00, 8'h22, 8'h01, 8'h02, 8'h03, 8'h04}, `BLRR_NAK);
    results();
  end
endmodule // test_boot_loader_run_reset_cmds
`default_nettype wire
